// File: test_tpwm_timer.sv
// Testbench: register access and measured waveforms of the timer PWM block
`timescale 1ns/100ps
module test_tpwm_timer;
   import tpwm_pkg::*;
   logic                pclk;
   logic                presetn;
   logic                psel;
   logic                penable;
   logic                pwrite;
   logic [7:0]          paddr;
   logic [31:0]         pwdata;
   logic [3:0]          pstrb;
   logic [31:0]         prdata;
   logic                pready;
   logic                pslverr;
   tpwm_pin_t           compare_out_a;
   tpwm_pin_t           compare_out_b;
   logic                overflow_flag;
   logic                match_flag_a;
   logic                match_flag_b;
   logic [31:0]         q;
   logic                e;
   int                  n_fail = 0;
   int                  compares = 0;

   tpwm_timer uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .compare_out_a(compare_out_a),
      .compare_out_b(compare_out_b), .overflow_flag(overflow_flag),
      .match_flag_a(match_flag_a), .match_flag_b(match_flag_b));

   // 200 MHz clock
   initial begin
      pclk = 1'b0;
      forever #2.5 pclk = ~pclk;
   end

   task complete_run;
      $display("counts: %0d compares, %0d mismatches", compares, n_fail);
      if (n_fail == 0 && compares > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : complete_run

   task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      compares++;
      if (got !== exp) begin
         $display("mismatch %s expected %h seen %h", name, exp, got);
         n_fail++;
      end
   endtask : chk

   // One bus transfer; the request is held until ready is sampled high
   task apb(input logic wr_en, input logic [7:0] a, input logic [31:0] d,
            output logic [31:0] rq, output logic re);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr_en;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      rq = prdata;
      re = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (n >= 20) begin
         $display("mismatch bus ready expected 1 seen timeout");
         n_fail++;
         complete_run();
      end
   endtask : apb

   task wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] rq;
      logic        re;
      apb(1'b1, a, d, rq, re);
   endtask : wr

   function automatic logic pin(input int ch);
      return ch != 0 ? compare_out_b.value : compare_out_a.value;
   endfunction : pin

   // Measure one full high and one full low phase of a pin, in clock cycles
   task measure(input int ch, output int hi, output int lo);
      int n;
      hi = 0;
      lo = 0;
      n = 0;
      while (pin(ch) !== 1'b0 && n < 10000) begin @(posedge pclk); n++; end
      while (pin(ch) !== 1'b1 && n < 10000) begin @(posedge pclk); n++; end
      while (pin(ch) === 1'b1 && n < 10000) begin @(posedge pclk); hi++; n++; end
      while (pin(ch) === 1'b0 && n < 10000) begin @(posedge pclk); lo++; n++; end
      if (n >= 10000) begin
         $display("mismatch pin %0d edges expected toggling seen timeout", ch);
         n_fail++;
         complete_run();
      end
   endtask : measure

   // Configure, let the waveform settle, then check overrides and phases
   task run(input logic [7:0] ca, cb, cta, ctb, input int settle, ahi, alo, bhi, blo);
      int hi;
      int lo;
      wr(ADDR_CMP_A, {24'h0, ca});
      wr(ADDR_CMP_B, {24'h0, cb});
      wr(ADDR_CTRL_A, {24'h0, cta});
      wr(ADDR_CTRL_B, {24'h0, ctb});
      repeat (settle) @(posedge pclk);
      chk("override a", {31'h0, cta[7:6] != 2'h0}, {31'h0, compare_out_a.override});
      chk("override b", {31'h0, cta[5:4] != 2'h0}, {31'h0, compare_out_b.override});
      measure(0, hi, lo);
      chk("pin a high", 32'(ahi), 32'(hi));
      chk("pin a low", 32'(alo), 32'(lo));
      if (bhi >= 0) begin
         measure(1, hi, lo);
         chk("pin b high", 32'(bhi), 32'(hi));
         chk("pin b low", 32'(blo), 32'(lo));
      end
      $display("test waveform ctrl_a %h ctrl_b %h done", cta, ctb);
   endtask : run

   // Both pins must hold one level for a whole period
   task steady(input logic ea, input logic eb);
      int bad;
      bad = 0;
      repeat (520) begin
         @(posedge pclk);
         if (compare_out_a.value !== ea || compare_out_b.value !== eb) bad++;
      end
      chk("steady level errors", 32'h0, 32'(bad));
   endtask : steady

   // Main sequence
   initial begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      pstrb = 4'h1;
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, ADDR_CTRL_A, 32'h0, q, e);
      chk("ctrl_a reset", 32'h0, q);
      wr(ADDR_CTRL_A, 32'hFF);
      apb(1'b0, ADDR_CTRL_A, 32'h0, q, e);
      chk("ctrl_a readback", 32'h000000F3, q);
      apb(1'b0, 8'h18, 32'h0, q, e);
      chk("unmapped error", 32'h1, {31'h0, e});
      pstrb <= 4'h0;
      wr(ADDR_CMP_A, 32'h33);
      pstrb <= 4'h1;
      apb(1'b0, ADDR_CMP_A, 32'h0, q, e);
      chk("strobe-less write", 32'h0, q);
      $display("test registers done");
      run(8'h80, 8'h40, 8'hB1, {5'h0, CS_DIV1}, 600, 256, 254, 382, 128);
      apb(1'b0, ADDR_FLAGS, 32'h0, q, e);
      chk("flags set", 32'h7, q);
      chk("flag pins", 32'h7, {29'h0, match_flag_b, match_flag_a, overflow_flag});
      wr(ADDR_CTRL_B, 32'h0);
      wr(ADDR_FLAGS, 32'h7);
      apb(1'b0, ADDR_FLAGS, 32'h0, q, e);
      chk("flags cleared", 32'h0, q);
      chk("flag pins cleared", 32'h0, {29'h0, match_flag_b, match_flag_a, overflow_flag});
      wr(ADDR_COUNT, 32'h5A);
      apb(1'b0, ADDR_COUNT, 32'h0, q, e);
      chk("counter readback", 32'h5A, q);
      $display("test flags done");
      run(8'h80, 8'h40, 8'hB1, {5'h0, CS_DIV8}, 5000, 2048, 2032, 3056, 1024);
      run(8'h64, 8'h32, 8'h61, {5'h1, CS_DIV1}, 600, 200, 200, 100, 100);
      run(8'h80, 8'h00, 8'h83, {5'h0, CS_DIV1}, 600, 129, 127, -1, -1);
      run(8'h10, 8'h00, 8'h40, {5'h0, CS_DIV1}, 600, 256, 256, -1, -1);
      wr(ADDR_CMP_A, 32'h0);
      wr(ADDR_CMP_B, 32'h0);
      wr(ADDR_CTRL_A, 32'hB1);
      repeat (600) @(posedge pclk);
      steady(1'b0, 1'b1);
      wr(ADDR_CMP_A, 32'hFF);
      wr(ADDR_CMP_B, 32'hFF);
      // New compares wait for TOP, then the level settles at the next BOTTOM
      repeat (800) @(posedge pclk);
      steady(1'b1, 1'b0);
      $display("test extremes done");
      complete_run();
   end
endmodule : test_tpwm_timer

// File: tpwm_check_asserts.sv
// Checker: bus handshake, pin override and sticky flag properties of the timer
`timescale 1ns/100ps
module tpwm_check
   import tpwm_pkg::*;
(
   // Clock and reset
   input wire logic                pclk,
   input wire logic                presetn,
   // Bus
   input wire logic                psel,
   input wire logic                penable,
   input wire logic                pwrite,
   input wire logic [7:0]          paddr,
   input wire logic [31:0]         pwdata,
   input wire logic [3:0]          pstrb,
   input wire logic [31:0]         prdata,
   input wire logic                pready,
   input wire logic                pslverr,
   // Outputs
   input wire tpwm_pkg::tpwm_pin_t compare_out_a,
   input wire tpwm_pkg::tpwm_pin_t compare_out_b,
   input wire logic                overflow_flag,
   input wire logic                match_flag_a,
   input wire logic                match_flag_b
);
   logic clr_ovf_q;
   logic clr_ma_q;
   logic clr_mb_q;
   wire logic acc_wr = psel && penable && pready && pwrite && pstrb[0];
   wire logic mapped = (paddr <= ADDR_FLAGS) && (paddr[1:0] == 2'h0);

   // Remember clearing writes so a falling flag can be traced to its cause
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         clr_ovf_q <= 1'b0;
         clr_ma_q  <= 1'b0;
         clr_mb_q  <= 1'b0;
      end else begin
         clr_ovf_q <= acc_wr && paddr == ADDR_FLAGS && pwdata[FL_OVF_BIT];
         clr_ma_q  <= acc_wr && paddr == ADDR_FLAGS && pwdata[FL_MA_BIT];
         clr_mb_q  <= acc_wr && paddr == ADDR_FLAGS && pwdata[FL_MB_BIT];
      end
   end

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   property p_ready_next; psel && !penable |=> pready; endproperty
   property p_ready_access; pready |-> psel && penable; endproperty
   property p_ready_pulse; pready |=> !pready; endproperty
   property p_err_decode; pready |-> (pslverr == !mapped); endproperty
   property p_read_upper; pready && !pwrite |-> prdata[31:8] == 24'h000000; endproperty
   property p_ovr_a;
      logic [1:0] act;
      (acc_wr && paddr == ADDR_CTRL_A, act = pwdata[7:6]) |->
         ##2 (compare_out_a.override == (act != 2'h0));
   endproperty
   property p_ovr_b;
      logic [1:0] act;
      (acc_wr && paddr == ADDR_CTRL_A, act = pwdata[5:4]) |->
         ##2 (compare_out_b.override == (act != 2'h0));
   endproperty
   property p_ovf_sticky; $fell(overflow_flag) |-> clr_ovf_q; endproperty
   property p_ma_sticky; $fell(match_flag_a) |-> clr_ma_q; endproperty
   property p_mb_sticky; $fell(match_flag_b) |-> clr_mb_q; endproperty

   a_ready_next: assert property (p_ready_next) else $error("no ready after setup");
   a_ready_access: assert property (p_ready_access) else $error("ready outside access");
   a_ready_pulse: assert property (p_ready_pulse) else $error("ready longer than a cycle");
   a_err_decode: assert property (p_err_decode) else $error("slave error decode wrong");
   a_read_upper: assert property (p_read_upper) else $error("read data upper bits set");
   a_ovr_a: assert property (p_ovr_a) else $error("pin a override wrong");
   a_ovr_b: assert property (p_ovr_b) else $error("pin b override wrong");
   a_ovf_sticky: assert property (p_ovf_sticky) else $error("overflow flag lost");
   a_ma_sticky: assert property (p_ma_sticky) else $error("match flag a lost");
   a_mb_sticky: assert property (p_mb_sticky) else $error("match flag b lost");

   c_ctrl_write: cover property (acc_wr && paddr == ADDR_CTRL_A);
   c_err: cover property (pslverr);
   c_ovf: cover property ($rose(overflow_flag));
endmodule : tpwm_check

bind tpwm_timer tpwm_check u_check (.pclk(pclk), .presetn(presetn), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
   .prdata(prdata), .pready(pready), .pslverr(pslverr), .compare_out_a(compare_out_a),
   .compare_out_b(compare_out_b), .overflow_flag(overflow_flag),
   .match_flag_a(match_flag_a), .match_flag_b(match_flag_b));

// File: tpwm_pkg.sv
// Package: register map, field layout, modes and timing constants of the timer PWM block
// Contract
// R1: Phase correct when waveform mode is 1 or 5
// R2: Count up to TOP, then down to BOTTOM
// R3: TOP is 0xFF in mode 1, compare A in 5
// R4: Non-inverting clears on up match, sets down
// R5: Channel A phase correct action codes decoded
// R6: Counter holds TOP for one tick
// R7: Overflow flag set on reaching BOTTOM
// R8: Toggle on match only for channel A
// R9: Period 510 ticks, prescale 1/8/64/256/1024
// R10: BOTTOM compare gives low, MAX gives high
// R11: Output at MAX equals up-match result
// R12: Missed up match still transitions at BOTTOM
// R13: Prescaled tick is a clock enable
// R14: Nonzero A action overrides port pin
// R15: Nonzero B action overrides port pin
// R16: Non-PWM action codes: off, toggle, clear, set; channel B toggle has no effect
// R17: Fast PWM codes: toggle, clear/set at TOP
// R18: Compare equal TOP with high bit: match ignored
// R19: Control A layout, bits 3:2 read zero
// R20: Mode bit 2 lives in control B
// R21: MAX is 0xFF, BOTTOM is 0x00
// R22: Channel B code 01 reserved in phase correct
// R23: Match flag set when counter equals compare
// R24: Compare values buffered, loaded at TOP
package tpwm_pkg;
   // Register byte addresses
   localparam logic [7:0] ADDR_CTRL_A   = 8'h00;
   localparam logic [7:0] ADDR_CTRL_B   = 8'h04;
   localparam logic [7:0] ADDR_COUNT    = 8'h08;
   localparam logic [7:0] ADDR_CMP_A    = 8'h0C;
   localparam logic [7:0] ADDR_CMP_B    = 8'h10;
   localparam logic [7:0] ADDR_FLAGS    = 8'h14;
   // Control A fields
   localparam int        CA_ACT_A_LSB  = 6;
   localparam int        CA_ACT_B_LSB  = 4;
   localparam logic [7:0] CA_WMASK     = 8'hF3;
   localparam logic [7:0] CA_RESET     = 8'h00;
   // Control B fields
   localparam int        CB_WGM2_BIT   = 3;
   localparam logic [7:0] CB_WMASK     = 8'h0F;
   // Flag register bits
   localparam int        FL_OVF_BIT    = 0;
   localparam int        FL_MA_BIT     = 1;
   localparam int        FL_MB_BIT     = 2;
   // Counter values
   localparam logic [7:0] CNT_MAX      = 8'hFF;
   localparam logic [7:0] CNT_BOTTOM   = 8'h00;
   // Action codes
   localparam logic [1:0] ACT_OFF      = 2'h0;
   localparam logic [1:0] ACT_TOGGLE   = 2'h1;
   localparam logic [1:0] ACT_CLEAR    = 2'h2;
   localparam logic [1:0] ACT_SET      = 2'h3;
   // Prescale divisors and the dual-slope period
   localparam int        PRE_DIV_1     = 1;
   localparam int        PRE_DIV_8     = 8;
   localparam int        PRE_DIV_64    = 64;
   localparam int        PRE_DIV_256   = 256;
   localparam int        PRE_DIV_1024  = 1024;
   localparam int        PC_PERIOD_TICKS = 510;
   localparam logic [2:0] CS_STOP      = 3'h0;
   localparam logic [2:0] CS_DIV1      = 3'h1;
   localparam logic [2:0] CS_DIV8      = 3'h2;
   localparam logic [2:0] CS_DIV64     = 3'h3;
   localparam logic [2:0] CS_DIV256    = 3'h4;
   localparam logic [2:0] CS_DIV1024   = 3'h5;

   typedef enum logic [1:0] {TPWM_NORMAL, TPWM_CTC, TPWM_FAST, TPWM_PHASE} tpwm_kind_t;

   // Output pin carrier
   typedef struct packed {
      logic value;
      logic override;
   } tpwm_pin_t;
endpackage : tpwm_pkg

// File: tpwm_prescale.sv
// Prescaler: produces the timer tick enable from the bus clock
`timescale 1ns/100ps
module tpwm_prescale (
   // Clock and reset
   input  wire logic       pclk,
   input  wire logic       presetn,
   // Clock select
   input  wire logic [2:0] clk_select,
   // Tick out
   output logic            tick_enable
);
   import tpwm_pkg::*;

   logic [9:0] div_count;

   // Free-running divider; taps pick the division
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         div_count <= 10'h000;
      end else begin
         div_count <= div_count + 10'h001;
      end
   end

   // One-cycle enable, never a derived clock  R13 R9
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tick_enable <= 1'b0;
      end else begin
         case (clk_select)
            CS_DIV1:    tick_enable <= 1'b1;
            CS_DIV8:    tick_enable <= (div_count[2:0] == 3'h7);
            CS_DIV64:   tick_enable <= (div_count[5:0] == 6'h3F);
            CS_DIV256:  tick_enable <= (div_count[7:0] == 8'hFF);
            CS_DIV1024: tick_enable <= (div_count == 10'h3FF);
            default:    tick_enable <= 1'b0;
         endcase
      end
   end
endmodule : tpwm_prescale

// File: tpwm_timer.sv
// Top: 8-bit timer with APB registers and two compare outputs
//
// Our own choices: the APB register port and the register addresses.
`timescale 1ns/100ps
module tpwm_timer (
   // Clock and reset
   input  wire logic        pclk,
   input  wire logic        presetn,
   // APB slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   input  wire logic [3:0]  pstrb,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   // Compare outputs
   output tpwm_pkg::tpwm_pin_t compare_out_a,
   output tpwm_pkg::tpwm_pin_t compare_out_b,
   // Flags as levels
   output logic             overflow_flag,
   output logic             match_flag_a,
   output logic             match_flag_b
);
   import tpwm_pkg::*;

   logic [7:0] timer_control_a;
   logic [7:0] timer_control_b;
   logic [7:0] counter_value;
   logic [7:0] compare_a_value;
   logic [7:0] compare_b_value;
   logic [7:0] compare_a_buf;
   logic [7:0] compare_b_buf;
   logic       count_down;
   logic       out_a;
   logic       out_b;
   logic       tick_enable;
   logic       wr_en;
   logic       rd_en;
   logic       count_written;
   logic [2:0] waveform_mode;
   tpwm_kind_t kind;
   logic [7:0] top_value;
   logic [7:0] next_count;
   logic       next_down;
   logic       at_top;
   logic       hit_a;
   logic       hit_b;
   logic       wrap_bottom;

   // Mode bit 2 comes from control B  R20
   assign waveform_mode = {timer_control_b[CB_WGM2_BIT], timer_control_a[1:0]};

   // Waveform mode decode, shared by counting and both channels
   function automatic tpwm_kind_t decode_kind(input logic [2:0] wm);
      case (wm)
         3'h1, 3'h5: decode_kind = TPWM_PHASE; // R1
         3'h2:       decode_kind = TPWM_CTC;
         3'h3, 3'h7: decode_kind = TPWM_FAST;
         default:    decode_kind = TPWM_NORMAL;
      endcase
   endfunction : decode_kind

   assign kind = decode_kind(waveform_mode);

   // TOP selection  R3 R21
   always_comb begin
      if (waveform_mode[2] || kind == TPWM_CTC) begin
         top_value = compare_a_value; // R3
      end else begin
         top_value = CNT_MAX;
      end
   end

   assign at_top = (counter_value == top_value);
   assign wr_en  = psel && penable && pwrite;
   assign rd_en  = psel && !penable && !pwrite;
   assign count_written = wr_en && paddr == ADDR_COUNT && pstrb[0];

   // Writing the counter blocks the match on the next tick
   logic block_match;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         block_match <= 1'b0;
      end else if (count_written) begin
         block_match <= 1'b1;
      end else if (tick_enable) begin
         block_match <= 1'b0;
      end
   end

   assign hit_a = tick_enable && !block_match && counter_value == compare_a_value; // R23
   assign hit_b = tick_enable && !block_match && counter_value == compare_b_value; // R23

   // Next count and direction per mode
   always_comb begin
      next_count = counter_value;
      next_down  = count_down;
      case (kind)
         TPWM_PHASE: begin
            if (at_top && !count_down) begin
               next_down = 1'b1; // R6 TOP held one tick as the turn point
               next_count = counter_value - 8'h01;
            end else if (count_down && counter_value == CNT_BOTTOM) begin
               next_down = 1'b0; // R2
               next_count = counter_value + 8'h01;
            end else if (count_down) begin
               next_count = counter_value - 8'h01;
            end else begin
               next_count = counter_value + 8'h01; // R2
            end
            if (at_top && !count_down && counter_value == CNT_BOTTOM) begin
               next_count = CNT_BOTTOM; // Degenerate TOP of zero holds BOTTOM for one tick, then the count moves on to 1
            end
         end
         TPWM_CTC, TPWM_FAST: begin
            next_down = 1'b0;
            next_count = at_top ? CNT_BOTTOM : counter_value + 8'h01;
         end
         default: begin
            next_down = 1'b0;
            next_count = counter_value + 8'h01;
         end
      endcase
   end

   // Overflow point per mode; phase correct marks the tick that enters BOTTOM
   always_comb begin
      case (kind)
         TPWM_PHASE: begin
            wrap_bottom = tick_enable && count_down && next_count == CNT_BOTTOM; // R7
         end
         TPWM_FAST: begin
            wrap_bottom = tick_enable && (at_top || counter_value == CNT_MAX);
         end
         default: begin
            wrap_bottom = tick_enable && counter_value == CNT_MAX;
         end
      endcase
   end

   // Counter and direction, advanced only on the tick enable  R13
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         counter_value <= CNT_BOTTOM;
         count_down    <= 1'b0;
      end else if (count_written) begin
         counter_value <= pwdata[7:0];
      end else if (tick_enable) begin
         counter_value <= next_count;
         count_down    <= next_down;
      end
   end

   // Active compare registers: loaded at TOP in PWM modes, else at once  R24
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         compare_a_value <= CNT_BOTTOM;
         compare_b_value <= CNT_BOTTOM;
      end else if (kind == TPWM_NORMAL || kind == TPWM_CTC) begin
         compare_a_value <= compare_a_buf;
         compare_b_value <= compare_b_buf;
      end else if (tick_enable && at_top && !count_down) begin
         compare_a_value <= compare_a_buf; // R24
         compare_b_value <= compare_b_buf;
      end
   end

   // Output action for one channel; toggle exists only where allowed
   function automatic logic [1:0] act_op(input tpwm_kind_t k, input logic [1:0] act,
                                         input logic tog_ok, input logic hit, input logic down,
                                         input logic top_evt, input logic cmp_is_top);
      // Returns {change, value}; value 1 with change 0 means toggle request
      act_op = 2'b00;
      if (act == ACT_TOGGLE) begin
         if (tog_ok && hit) begin
            act_op = 2'b01; // R8
         end
      end else if (act != ACT_OFF) begin
         case (k)
            TPWM_PHASE: begin
               if (hit && cmp_is_top) begin
                  act_op = {1'b1, ~act[0]}; // R18 TOP match ignored, the down level holds
               end else if (hit) begin
                  act_op = {1'b1, act[0] ^ down}; // R4 R10
               end
            end
            TPWM_FAST: begin
               if (hit && !cmp_is_top) begin
                  act_op = {1'b1, act[0]}; // R17 R18
               end else if (top_evt) begin
                  act_op = {1'b1, ~act[0]}; // R17
               end
            end
            default: begin
               if (hit) begin
                  act_op = {1'b1, act[0]}; // R16
               end
            end
         endcase
      end
   endfunction : act_op

   logic [1:0] op_a;
   logic [1:0] op_b;
   logic       top_tick;
   logic       bottom_fix;
   logic       down_a;
   logic       down_b;
   assign top_tick = tick_enable && at_top;

   // A match at BOTTOM counts as up-counting, so a BOTTOM compare keeps one level  R10
   assign down_a = count_down && compare_a_value != CNT_BOTTOM;
   assign down_b = count_down && compare_b_value != CNT_BOTTOM;

   // Channel A toggles when waveform mode bit 2 is set or in non-PWM modes  R5 R16
   assign op_a = act_op(kind, timer_control_a[7:6],
                        waveform_mode[2] || kind == TPWM_NORMAL || kind == TPWM_CTC,
                        hit_a, down_a, top_tick, compare_a_value == top_value);
   // Channel B: toggle requested only outside PWM and never applied to out_b; reserved in PWM modes  R22 R8
   assign op_b = act_op(kind, timer_control_a[5:4],
                        kind == TPWM_NORMAL || kind == TPWM_CTC,
                        hit_b, down_b, top_tick, compare_b_value == top_value);

   // Turning at BOTTOM re-establishes the up-match state  R11 R12
   assign bottom_fix = tick_enable && kind == TPWM_PHASE && count_down
                       && counter_value == CNT_BOTTOM;

   // Output level registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         out_a <= 1'b0;
         out_b <= 1'b0;
      end else begin
         if (bottom_fix && timer_control_a[7] && !hit_a) begin
            out_a <= timer_control_a[6] ^ (compare_a_value != CNT_BOTTOM); // R11 R12
         end else if (op_a == 2'b01) begin
            out_a <= ~out_a;
         end else if (op_a[1]) begin
            out_a <= op_a[0];
         end
         if (bottom_fix && timer_control_a[5] && !hit_b) begin
            out_b <= timer_control_a[4] ^ (compare_b_value != CNT_BOTTOM); // R11 R12
         end else if (op_b[1]) begin
            out_b <= op_b[0];
         end
      end
   end

   // Pin drive: override whenever the action field is nonzero
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         compare_out_a <= '0;
         compare_out_b <= '0;
      end else begin
         compare_out_a.override <= |timer_control_a[7:6]; // R14
         compare_out_b.override <= |timer_control_a[5:4]; // R15
         compare_out_a.value    <= out_a;
         compare_out_b.value    <= out_b;
      end
   end

   // Write-one clears honour the byte strobe like every other register write
   logic       clr_wr;
   assign clr_wr = wr_en && pstrb[0] && paddr == ADDR_FLAGS;

   // Event flags: set wins over a write-one clear  R7 R23
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         overflow_flag <= 1'b0;
         match_flag_a  <= 1'b0;
         match_flag_b  <= 1'b0;
      end else begin
         if (wrap_bottom) begin
            overflow_flag <= 1'b1; // R7
         end else if (clr_wr && pwdata[FL_OVF_BIT]) begin
            overflow_flag <= 1'b0;
         end
         if (hit_a) begin
            match_flag_a <= 1'b1;
         end else if (clr_wr && pwdata[FL_MA_BIT]) begin
            match_flag_a <= 1'b0;
         end
         if (hit_b) begin
            match_flag_b <= 1'b1;
         end else if (clr_wr && pwdata[FL_MB_BIT]) begin
            match_flag_b <= 1'b0;
         end
      end
   end

   // Register writes; reserved bits of control A stay zero  R19
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         timer_control_a <= CA_RESET;
         timer_control_b <= CA_RESET;
         compare_a_buf   <= CNT_BOTTOM;
         compare_b_buf   <= CNT_BOTTOM;
      end else if (wr_en && pstrb[0]) begin
         case (paddr)
            ADDR_CTRL_A: timer_control_a <= pwdata[7:0] & CA_WMASK; // R19
            ADDR_CTRL_B: timer_control_b <= pwdata[7:0] & CB_WMASK;
            ADDR_CMP_A:  compare_a_buf   <= pwdata[7:0];
            ADDR_CMP_B:  compare_b_buf   <= pwdata[7:0];
            default:     ;
         endcase
      end
   end

   // Read data is captured in setup, so the access phase answers at once
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata  <= 32'h00000000;
         pslverr <= 1'b0;
         pready  <= 1'b0;
      end else begin
         pready  <= psel && !penable;
         pslverr <= psel && !penable && !(paddr inside {ADDR_CTRL_A, ADDR_CTRL_B,
                    ADDR_COUNT, ADDR_CMP_A, ADDR_CMP_B, ADDR_FLAGS});
         if (rd_en) begin
            case (paddr)
               ADDR_CTRL_A: prdata <= {24'h000000, timer_control_a};
               ADDR_CTRL_B: prdata <= {24'h000000, timer_control_b};
               ADDR_COUNT:  prdata <= {24'h000000, counter_value};
               ADDR_CMP_A:  prdata <= {24'h000000, compare_a_buf};
               ADDR_CMP_B:  prdata <= {24'h000000, compare_b_buf};
               ADDR_FLAGS:  prdata <= {29'h00000000, match_flag_b, match_flag_a,
                                       overflow_flag};
               default:     prdata <= 32'h00000000;
            endcase
         end
      end
   end

   // Tick source; the clock select lives in control B bits 2:0
   tpwm_prescale u_prescale (
      .pclk        (pclk),
      .presetn     (presetn),
      .clk_select  (timer_control_b[2:0]),
      .tick_enable (tick_enable)
   );
endmodule : tpwm_timer
